// ==== bench/msso_mem_model.sv ====
// external memory stand-in facing the strobe and select pins
// assumes pins are registered on clk and the bench offers the read word on rdata
`timescale 1ns/1ps
module msso_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pins from the block
    input wire msso_pkg::msso_pins_s mem_pins,
    input wire logic memory_clock_out,
    // read word offered by the bench
    input wire logic [31:0] rdata,
    // pins back to the block
    output logic memory_clock_return,
    output logic [31:0] data_in
);
    import msso_pkg::*;
    logic sel; // a device is selected and the bus is turned round
    logic [31:0] junk_r; // floating bus stand-in
    // board trace ties the clock output straight back
    assign memory_clock_return = memory_clock_out;
    // any select or row strobe low while the block is not driving
    assign sel = mem_pins.data_oe_n & ~(&{mem_pins.general_select_n,
        mem_pins.expansion_card_select_n, mem_pins.slot2_select_n,
        mem_pins.bank0_sdram_select_n, mem_pins.bank1_row_or_select_n,
        mem_pins.bank0_row_strobe_n});
    // no pull on the bus: idle shows the inverse of the last value, so stale data never matches
    assign data_in = sel ? rdata : junk_r;
    // pattern changes every cycle while nobody drives
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            junk_r <= 32'h0;
        end else begin
            junk_r <= ~data_in;
        end
    end
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the memory strobe and select outputs
// assumes msso_pkg, msso_top and msso_mem_model are compiled first
`timescale 1ns/1ps
module tb;
    import msso_pkg::*;
    logic clk = 1'b0; // 25 MHz block clock
    logic rst_b = 1'b0; // reset, low at start
    logic req_valid = 1'b0;
    msso_req_s req = '0;
    logic endian = 1'b0; // strap, 1 big endian
    logic hold = 1'b0; // clock enable hold
    logic hold_q = 1'b0; // hold seen at last edge
    logic live = 1'b0; // one edge past reset
    logic mclk_q = 1'b0; // memory clock at last negedge
    logic [31:0] rdata = 32'h0; // word the memory answers with
    logic req_ready, rd_valid, memory_clock_out, sdram_clock_enable, memory_clock_return;
    logic [31:0] rd_data, data_in;
    msso_pins_s mem_pins;
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 32'hbd67;
    logic [31:0] exp_q[$]; // expected read words in issue order

    always #20 clk = ~clk;

    msso_top i_msso_top (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .endian_select(endian),
        .sdram_clock_hold(hold), .mem_pins(mem_pins), .memory_clock_out(memory_clock_out),
        .sdram_clock_enable(sdram_clock_enable), .memory_clock_return(memory_clock_return),
        .data_in(data_in));

    msso_mem_model i_msso_mem_model (.clk(clk), .rst_b(rst_b), .mem_pins(mem_pins),
        .memory_clock_out(memory_clock_out), .rdata(rdata),
        .memory_clock_return(memory_clock_return), .data_in(data_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // strobe and select pins as one vector, oe first
    function automatic logic [20:0] pv();
        return {mem_pins.data_oe_n, mem_pins.write_strobe_n, mem_pins.lane3_column_strobe_n,
            mem_pins.lane2_column_strobe_n, mem_pins.lane1_column_strobe_n,
            mem_pins.lane0_column_strobe_n, mem_pins.bank0_row_strobe_n,
            mem_pins.bank1_row_or_select_n, mem_pins.bank0_sdram_select_n,
            mem_pins.upper_byte_mask, mem_pins.low_byte_mask, mem_pins.general_select_n,
            mem_pins.expansion_card_select_n, mem_pins.slot2_select_n};
    endfunction

    // byte reversal of a word, the bench's own copy for big endian
    function automatic logic [31:0] bsw(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // hold the strap, reset for three cycles, then release
    task automatic do_reset(input logic be);
        @(posedge clk);
        #1 rst_b = 1'b0;
        endian = be;
        repeat (3) @(posedge clk);
        check(pv(), 21'h1FFFFF, "pins in reset");
        check({memory_clock_out, sdram_clock_enable, req_ready, rd_valid}, 4'h0,
            "reset outs");
        #1 rst_b = 1'b1;
    endtask

    // one access, phase by phase against the model
    task automatic do_access(input msso_req_s r);
        logic [3:0] l, pl, ln;
        logic [31:0] d, pd, m, rexp, rm;
        logic [20:0] es, ep, care;
        logic [9:0] sl;
        logic [1:0] mk;
        logic sd, dr, s16, w16;
        int n;
        sd = (r.kind == MSSO_SDRAM);
        dr = (r.kind == MSSO_DRAM);
        s16 = (r.kind == MSSO_EXPANSION) || (r.kind == MSSO_SLOT2) ||
            (r.kind == MSSO_GENERAL && r.port16);
        w16 = sd || (dr && r.port16); // 16-bit sdram or dram on bits 15:0
        l = endian ? {r.lanes[0], r.lanes[1], r.lanes[2], r.lanes[3]} : r.lanes;
        d = endian ? bsw(r.wdata) : r.wdata;
        m = s16 ? 32'hFFFF0000 : (sd && r.sdram8) ? 32'h000000FF :
            w16 ? 32'h0000FFFF : 32'hFFFFFFFF;
        pl = s16 ? {l[1:0], 2'h0} : (sd && r.sdram8) ? {3'h0, l[0]} :
            w16 ? {2'h0, l[1:0]} : l;
        pd = (s16 ? {d[15:0], 16'h0} : d) & m;
        mk = sd ? {r.sdram8 | ~pl[1], ~pl[0]} : 2'h3;
        ln = sd ? 4'hE : (dr || r.write) ? ~pl : 4'hF;
        sl[9:6] = (r.kind == MSSO_GENERAL) ? ~(4'h1 << r.region) : 4'hF;
        sl[5:2] = (r.kind == MSSO_EXPANSION) ? ~(4'h1 << r.region) : 4'hF;
        sl[1:0] = (r.kind == MSSO_SLOT2) ? ~pl[3:2] : 2'h3;
        es = {!r.write, !r.write, ln, !(dr && !r.bank), !((sd || dr) && r.bank),
            !(sd && !r.bank), mk, sl};
        ep = {!r.write, 1'b1, 4'hF, !(sd || (dr && !r.bank)), es[13:0]};
        care = sd ? 21'h18FFFF : 21'h1FFFFF; // upper lane strobes free for sdram
        rm = s16 ? 32'h0000FFFF : m;
        rexp = s16 ? {16'h0, rdata[31:16]} : rdata & m;
        // big endian hands the realigned word back byte reversed
        if (endian) begin
            rm = bsw(rm);
            rexp = bsw(rexp);
        end
        if (!r.write) exp_q.push_back(rexp);
        n = 0;
        @(posedge clk);
        #1 req = r;
        req_valid = 1'b1;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(n < 20, 1'b1, "ready wait");
        @(posedge clk);
        #1 req_valid = 1'b0;
        req = ~r;
        @(negedge clk);
        check(pv(), ep, "setup pins");
        @(negedge clk);
        check(req_ready, 1'b0, "busy refuses");
        @(negedge clk);
        check(pv() & care, es & care, "strobe pins");
        if (r.write) check(mem_pins.data_out & m, pd, "write data");
        @(negedge clk);
        @(negedge clk);
        check(pv(), 21'h1FFFFF, "recover idle");
        check(rd_valid, !r.write, "read pulse");
        if (rd_valid === 1'b1 && exp_q.size() > 0) begin
            check(rd_data & rm, exp_q.pop_front(), "read data");
        end
    endtask

    // random hold, changed just after each edge
    always @(posedge clk) begin
        hold_q <= hold;
        #1 hold = $random(seed);
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) live <= 1'b0;
        else live <= 1'b1;
    end

    // clock enable follows hold, memory clock toggles every cycle
    always @(negedge clk) begin
        if (rst_b && live) begin
            check(sdram_clock_enable, !hold_q, "clock enable");
            check(memory_clock_out, !mclk_q, "memory clock");
        end
        mclk_q = memory_clock_out;
    end

    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end

    initial begin
        msso_req_s r;
        int rnd;
        do_reset(1'b0);
        // every kind, read and write, both banks, all regions
        for (int j = 0; j < 2; j++) begin
            for (int k = 0; k < 5; k++) begin
                for (int i = 0; i < 4; i++) begin
                    rnd = $random(seed);
                    r.kind = msso_kind_e'(k[2:0]);
                    r.write = i[0];
                    r.bank = i[1];
                    r.region = i[1:0];
                    r.port16 = rnd[0]; // dram and general honour it, the rest ignore it
                    r.sdram8 = rnd[1];
                    r.lanes = rnd[7:4] | 4'h1;
                    r.wdata = $random(seed);
                    rdata = $random(seed);
                    do_access(r);
                end
            end
        end
        // big endian strap: reversed lanes on wide and narrow static writes and reads
        do_reset(1'b1);
        for (int i = 0; i < 8; i++) begin
            rnd = $random(seed);
            r = '0;
            r.kind = i[0] ? MSSO_EXPANSION : (i[1] ? MSSO_SLOT2 : MSSO_GENERAL);
            r.write = !i[2];
            r.region = i[1:0];
            r.port16 = rnd[4];
            r.lanes = rnd[3:0] | 4'hC;
            r.wdata = $random(seed);
            rdata = $random(seed);
            do_access(r);
        end
        finish_test();
    end
endmodule

// ==== design/msso_params.svh ====
// timing counts and idle levels for the memory strobe and select outputs
// assumes the block clock runs at 25 MHz
`ifndef MSSO_PARAMS_SVH
`define MSSO_PARAMS_SVH

// block clock
`define MSSO_CLK_NS 40
`define MSSO_CLK_KHZ 25000

// nominal memory clock for the sdram devices
`define MSSO_MCLK_KHZ 73728

// half period of the memory clock, rounded down, never below one cycle
`define MSSO_MCLK_HALF_CYC \
    (((`MSSO_CLK_KHZ / (2 * `MSSO_MCLK_KHZ)) > 0) ? (`MSSO_CLK_KHZ / (2 * `MSSO_MCLK_KHZ)) : 1)

// least times of the access phases
`define MSSO_SETUP_NS 40
`define MSSO_STROBE_NS 120
`define MSSO_RECOVER_NS 40

// phase lengths in cycles, rounded up
`define MSSO_SETUP_CYC ((`MSSO_SETUP_NS + `MSSO_CLK_NS - 1) / `MSSO_CLK_NS)
`define MSSO_STROBE_CYC ((`MSSO_STROBE_NS + `MSSO_CLK_NS - 1) / `MSSO_CLK_NS)
`define MSSO_RECOVER_CYC ((`MSSO_RECOVER_NS + `MSSO_CLK_NS - 1) / `MSSO_CLK_NS)

// cycles the endian strap needs to pass the synchroniser
`define MSSO_STRAP_CYC 3

// idle level of every active-low strobe, select and mask pin
`define MSSO_PIN_IDLE 1'b1

`endif

// ==== design/msso_pkg.sv ====
// types shared by the memory strobe and select output block
// assumes msso_params.svh is on the include path
package msso_pkg;

    // access phases, gray coded along idle, setup, strobe, recover
    typedef enum logic [1:0] {
        MSSO_IDLE = 2'h0,
        MSSO_SETUP = 2'h1,
        MSSO_STROBE = 2'h3,
        MSSO_RECOVER = 2'h2
    } msso_state_e;

    // kind of target behind the access
    typedef enum logic [2:0] {
        MSSO_SDRAM = 3'h0,
        MSSO_DRAM = 3'h1,
        MSSO_GENERAL = 3'h2,
        MSSO_EXPANSION = 3'h3,
        MSSO_SLOT2 = 3'h4
    } msso_kind_e;

    // one access request from the bus unit
    typedef struct packed {
        msso_kind_e kind;    // target kind
        logic write;         // 1 write, 0 read
        logic bank;          // dram or sdram bank
        logic [1:0] region;  // general or expansion select number
        logic port16;        // general region or dram is 16 bits wide
        logic sdram8;        // sdram is 8 bits wide
        logic [3:0] lanes;   // byte enables, request view
        logic [31:0] wdata;  // write data, request view
    } msso_req_s;

    // registered memory pins, data first so idle is zeros then ones
    typedef struct packed {
        logic [31:0] data_out;
        logic data_oe_n;
        logic write_strobe_n;
        logic lane0_column_strobe_n;
        logic lane1_column_strobe_n;
        logic lane2_column_strobe_n;
        logic lane3_column_strobe_n;
        logic bank0_row_strobe_n;
        logic bank1_row_or_select_n;
        logic bank0_sdram_select_n;
        logic upper_byte_mask;
        logic low_byte_mask;
        logic [3:0] general_select_n;
        logic [3:0] expansion_card_select_n;
        logic [1:0] slot2_select_n;
    } msso_pins_s;

endpackage

// ==== design/msso_sync.sv ====
// two flip-flop synchroniser for pin inputs
// assumes d comes from outside the clk domain; q is the second stage
`timescale 1ns/1ps
module msso_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // asynchronous in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // both stages as one state word
    typedef struct packed {
        logic [W-1:0] s1;  // first stage, read only by s2
        logic [W-1:0] s2;  // second stage
    } msso_sync_s;

    msso_sync_s s_r;
    msso_sync_s s_nxt;

    // shift one stage per clock
    always_comb begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    // flops clear to zero under reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;

endmodule

// ==== design/msso_top.sv ====
// strobe, row, column, mask and chip select pin generation for external memory
// assumes one request at a time from the bus unit and a looped back memory clock
`timescale 1ns/1ps
`include "msso_params.svh"
module msso_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // access request
    input wire logic req_valid,
    input wire msso_pkg::msso_req_s req,
    output logic req_ready,
    // read answer
    output logic rd_valid,
    output logic [31:0] rd_data,
    // strap and control
    input wire logic endian_select,
    input wire logic sdram_clock_hold,
    // memory pins
    output msso_pkg::msso_pins_s mem_pins,
    output logic memory_clock_out,
    output logic sdram_clock_enable,
    input wire logic memory_clock_return,
    input wire logic [31:0] data_in
);
    import msso_pkg::*;

    // whole state of the block
    typedef struct packed {
        msso_state_e st;     // access phase
        logic [2:0] cnt;     // cycles left in phase
        msso_req_s req;      // latched request, bus view except wdata, which is already in pin order
        logic [3:0] lanes;   // lane enables on the pins
        logic [1:0] strap;   // strap settle count
        logic big;           // big endian
        logic ret_prev;      // last returned clock level
        logic [2:0] mdiv;    // memory clock divider
        logic mclk;          // memory clock level
        logic cke;           // sdram clock enable
        logic rd_valid;      // read answer pulse
        logic [31:0] rd_data;
        msso_pins_s pins;    // registered pins
    } msso_top_s;

    msso_top_s s_r;
    msso_top_s s_nxt;

    // synchronised pins: returned clock, strap, read data
    logic [33:0] sync_q;
    logic ret_s;
    logic big_s;
    logic [31:0] din_s;

    // data and returned clock share one synchroniser so skew stays matched
    msso_sync #(
        .W(34)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d({memory_clock_return, endian_select, data_in}),
        .q(sync_q)
    );

    assign ret_s = sync_q[33];
    assign big_s = sync_q[32];
    assign din_s = sync_q[31:0];

    // 16-bit static port, carried on bits 31:16
    function automatic logic static16(msso_req_s r);
        static16 = (r.kind == MSSO_EXPANSION) || (r.kind == MSSO_SLOT2) ||
            ((r.kind == MSSO_GENERAL) && r.port16);
    endfunction

    // byte order swap for big endian
    function automatic logic [31:0] bswap(logic [31:0] w);
        bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // next state, then pins from the next phase so pins line up with it
    always_comb begin
        logic [3:0] ln;
        logic [31:0] wd;
        logic [31:0] rx;
        logic act;
        logic stb;
        logic wr;
        logic [3:0] col;
        ln = '0;
        wd = '0;
        rx = '0;
        act = 1'b0;
        stb = 1'b0;
        wr = 1'b0;
        col = 4'h0;
        s_nxt = s_r;
        s_nxt.rd_valid = 1'b0;
        s_nxt.ret_prev = ret_s;
        s_nxt.cke = ~sdram_clock_hold;

        // free running memory clock divider
        if (s_r.mdiv == 3'h0) begin
            s_nxt.mclk = ~s_r.mclk;
            s_nxt.mdiv = 3'(`MSSO_MCLK_HALF_CYC - 1);
        end else begin
            s_nxt.mdiv = s_r.mdiv - 3'h1;
        end

        // sample the strap until it has crossed the synchroniser
        if (s_r.strap != 2'(`MSSO_STRAP_CYC)) begin
            s_nxt.big = big_s;
            s_nxt.strap = s_r.strap + 2'h1;
        end

        case (s_r.st)
            // wait for a request once byte order is known
            MSSO_IDLE: begin
                if (req_valid && req_ready) begin
                    // big endian reverses lanes and bytes first
                    ln = s_r.big ? {req.lanes[0], req.lanes[1], req.lanes[2],
                        req.lanes[3]} : req.lanes;
                    wd = s_r.big ? bswap(req.wdata) : req.wdata;
                    s_nxt.req = req;
                    s_nxt.req.wdata = wd;
                    s_nxt.lanes = ln;
                    // place data on the bits the port width owns
                    case (req.kind)
                        MSSO_SDRAM: begin
                            s_nxt.lanes = req.sdram8 ? (ln & 4'h1) : (ln & 4'h3);
                        end
                        MSSO_DRAM: begin
                            s_nxt.lanes = req.port16 ? (ln & 4'h3) : ln;
                        end
                        default: begin
                            // static 16-bit ports sit on bits 31:16
                            if (static16(req)) begin
                                s_nxt.lanes = {ln[1:0], 2'h0};
                                s_nxt.req.wdata = {wd[15:0], 16'h0};
                            end
                        end
                    endcase
                    s_nxt.st = MSSO_SETUP;
                    s_nxt.cnt = 3'(`MSSO_SETUP_CYC - 1);
                end
            end
            // selects and row strobe settle before the strobe
            MSSO_SETUP: begin
                if (s_r.cnt == 3'h0) begin
                    s_nxt.st = MSSO_STROBE;
                    s_nxt.cnt = 3'(`MSSO_STROBE_CYC - 1);
                end else begin
                    s_nxt.cnt = s_r.cnt - 3'h1;
                end
            end
            // strobe phase; reads latch on each returned clock rise
            MSSO_STROBE: begin
                if (!s_r.req.write && ret_s && !s_r.ret_prev) begin
                    rx = din_s;
                    if (static16(s_r.req)) begin
                        rx = {16'h0, rx[31:16]};
                    end
                    s_nxt.rd_data = s_r.big ? bswap(rx) : rx;
                end
                if (s_r.cnt == 3'h0) begin
                    s_nxt.st = MSSO_RECOVER;
                    s_nxt.cnt = 3'(`MSSO_RECOVER_CYC - 1);
                    s_nxt.rd_valid = !s_r.req.write;
                end else begin
                    s_nxt.cnt = s_r.cnt - 3'h1;
                end
            end
            // all strobes, selects and masks idle before the next access
            MSSO_RECOVER: begin
                if (s_r.cnt == 3'h0) begin
                    s_nxt.st = MSSO_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt - 3'h1;
                end
            end
            default: begin
                s_nxt.st = MSSO_IDLE;
            end
        endcase

        // pin levels for the next phase, everything idle by default
        act = (s_nxt.st == MSSO_SETUP) || (s_nxt.st == MSSO_STROBE);
        stb = (s_nxt.st == MSSO_STROBE);
        wr = s_nxt.req.write;
        col = 4'h0;
        s_nxt.pins = msso_pins_s'({32'h0,
            {($bits(msso_pins_s) - 32){`MSSO_PIN_IDLE}}});
        s_nxt.pins.data_out = s_nxt.req.wdata;
        s_nxt.pins.data_oe_n = !(act && wr);
        s_nxt.pins.write_strobe_n = !(stb && wr);
        case (s_nxt.req.kind)
            MSSO_SDRAM: begin
                // one column strobe, masks pick the bytes
                col = {3'h0, stb};
                s_nxt.pins.bank0_row_strobe_n = !(s_nxt.st == MSSO_SETUP);
                if (s_nxt.req.bank) begin
                    s_nxt.pins.bank1_row_or_select_n = !act;
                end else begin
                    s_nxt.pins.bank0_sdram_select_n = !act;
                end
                if (act) begin
                    s_nxt.pins.low_byte_mask = !s_nxt.lanes[0];
                    s_nxt.pins.upper_byte_mask = s_nxt.req.sdram8 || !s_nxt.lanes[1];
                end
            end
            MSSO_DRAM: begin
                // column strobe per byte lane, reads and writes
                col = stb ? s_nxt.lanes : 4'h0;
                if (s_nxt.req.bank) begin
                    s_nxt.pins.bank1_row_or_select_n = !act;
                end else begin
                    s_nxt.pins.bank0_row_strobe_n = !act;
                end
            end
            MSSO_GENERAL: begin
                col = (stb && wr) ? s_nxt.lanes : 4'h0;
                s_nxt.pins.general_select_n =
                    ~(act ? (4'h1 << s_nxt.req.region) : 4'h0);
            end
            MSSO_EXPANSION: begin
                col = (stb && wr) ? s_nxt.lanes : 4'h0;
                s_nxt.pins.expansion_card_select_n =
                    ~(act ? (4'h1 << s_nxt.req.region) : 4'h0);
            end
            MSSO_SLOT2: begin
                // high select for bits 31:24, low for 23:16
                col = (stb && wr) ? s_nxt.lanes : 4'h0;
                s_nxt.pins.slot2_select_n = ~(s_nxt.lanes[3:2] & {2{act}});
            end
            default: begin
                col = 4'h0;
            end
        endcase
        s_nxt.pins.lane0_column_strobe_n = !col[0];
        s_nxt.pins.lane1_column_strobe_n = !col[1];
        s_nxt.pins.lane2_column_strobe_n = !col[2];
        s_nxt.pins.lane3_column_strobe_n = !col[3];
    end

    // one register for all state; reset leaves every pin idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.pins <= msso_pins_s'({32'h0, {($bits(msso_pins_s) - 32){`MSSO_PIN_IDLE}}});
        end else begin
            s_r <= s_nxt;
        end
    end

    // handshake is combinational, everything else from flops
    assign req_ready = (s_r.st == MSSO_IDLE) && (s_r.strap == 2'(`MSSO_STRAP_CYC));
    assign rd_valid = s_r.rd_valid;
    assign rd_data = s_r.rd_data;
    assign mem_pins = s_r.pins;
    assign memory_clock_out = s_r.mclk;
    assign sdram_clock_enable = s_r.cke;

    // checks on the pins against the phase that drives them
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_we_on_write: assert property (
        (s_r.st == MSSO_STROBE) |-> (mem_pins.write_strobe_n == !s_r.req.write))
        else $error("write strobe does not follow the write phase");

    a_sdram_col: assert property (
        (s_r.st == MSSO_STROBE && s_r.req.kind == MSSO_SDRAM) |->
            (!mem_pins.lane0_column_strobe_n && mem_pins.lane3_column_strobe_n))
        else $error("sdram column strobe wrong");

    a_static_read_col: assert property (
        (s_r.req.kind >= MSSO_GENERAL && !s_r.req.write) |->
            (mem_pins.lane3_column_strobe_n && mem_pins.lane1_column_strobe_n))
        else $error("static read drove a write enable");

    a_row_bank0: assert property (
        (s_r.st == MSSO_SETUP && (s_r.req.kind == MSSO_SDRAM ||
            (s_r.req.kind == MSSO_DRAM && !s_r.req.bank))) |-> !mem_pins.bank0_row_strobe_n)
        else $error("bank 0 row strobe missing");

    a_bank1_select: assert property (
        (s_r.st != MSSO_IDLE && s_r.st != MSSO_RECOVER && s_r.req.bank &&
            s_r.req.kind <= MSSO_DRAM) |-> !mem_pins.bank1_row_or_select_n)
        else $error("bank 1 select missing");

    a_sdram_sel0: assert property (
        !mem_pins.bank0_sdram_select_n |-> (s_r.req.kind == MSSO_SDRAM && !s_r.req.bank))
        else $error("bank 0 sdram select on wrong access");

    a_mclk_toggle: assert property (
        $past(rst_b) |-> (s_r.mclk != $past(s_r.mclk)))
        else $error("memory clock stopped");

    a_strobe_len: assert property (
        $rose(s_r.st == MSSO_STROBE) |-> (s_r.st == MSSO_STROBE)[*3] ##1
            (s_r.st == MSSO_RECOVER && rd_valid == !s_r.req.write))
        else $error("strobe phase length or read answer wrong");

    a_exp_lanes: assert property (
        (s_r.req.kind == MSSO_EXPANSION) |->
            (mem_pins.lane0_column_strobe_n && mem_pins.lane1_column_strobe_n))
        else $error("expansion access used low lanes");

    a_idle_quiet: assert property (
        (s_r.st == MSSO_IDLE || s_r.st == MSSO_RECOVER) |->
            (mem_pins.write_strobe_n && mem_pins.general_select_n == 4'hF &&
            mem_pins.slot2_select_n == 2'h3 && mem_pins.data_oe_n))
        else $error("pins active outside an access");

    a_cke_follow: assert property (
        sdram_clock_hold |=> !sdram_clock_enable)
        else $error("clock enable ignored hold");

    c_sdram_write: cover property (
        (s_r.st == MSSO_STROBE && s_r.req.kind == MSSO_SDRAM && s_r.req.write));
    c_dram_read: cover property (rd_valid && s_r.req.kind == MSSO_DRAM);
    c_slot2_big: cover property (!mem_pins.slot2_select_n[1] && s_r.big);
    c_general16: cover property (s_r.st == MSSO_STROBE && static16(s_r.req) && s_r.req.write);

endmodule
